// *** logic/flash_host_pkg.sv ***
package flash_host_pkg;

	// Clock rate and pin timing, times in ns
	localparam int CLK_MHZ = 200;
	localparam int T_SETUP_NS = 20;
	localparam int T_STROBE_NS = 50;
	localparam int T_RECOVER_NS = 30;
	localparam int T_ACCESS_NS = 100;
	localparam int T_RESET_NS = 1000;

	// Least time to whole cycles, rounded up, never below one
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int SETUP_CYC = ns_to_cyc(T_SETUP_NS);
	localparam int STROBE_CYC = ns_to_cyc(T_STROBE_NS);
	localparam int RECOVER_CYC = ns_to_cyc(T_RECOVER_NS);
	localparam int ACCESS_CYC = ns_to_cyc(T_ACCESS_NS);
	localparam int RESET_CYC = ns_to_cyc(T_RESET_NS);

	// Flash address width (byte-wide part)
	localparam int FLASH_AW = 19;

	// Command codes sent on the low data byte
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_COMMIT = 8'hd0;
	localparam logic [7:0] CMD_WRITE_SETUP = 8'h40;
	localparam logic [7:0] CMD_READ_ARRAY = 8'hff;

	// Flash status byte: ready bit and error flag mask
	localparam int READY_BIT = 7;
	localparam logic [7:0] ERR_MASK = 8'h38;

	// Register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_ADDR = 8'h04;
	localparam logic [7:0] REG_WDATA = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0c;

	// Field positions
	localparam int CTRL_WP_BIT = 3;
	localparam int CTRL_HV_BIT = 4;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_FLASH_LSB = 8;
	localparam int STAT_DATA_LSB = 16;

	// Operations that software can start, and OP_NONE, which starts nothing
	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_READ = 3'b001,
		OP_PROG = 3'b010,
		OP_ERASE = 3'b011,
		OP_IDENT = 3'b100,
		OP_RESET = 3'b101
	} op_e;

endpackage

// *** logic/pin_cycle_if.sv ***
`timescale 1ns/10ps
// One flash bus cycle: request held until done pulses
interface pin_cycle_if import flash_host_pkg::*; ();
	logic req;
	logic wr;
	logic [FLASH_AW-1:0] addr;
	logic [7:0] wdata;
	logic done;
	logic [7:0] rdata;
	modport ctrl (output req, output wr, output addr, output wdata, input done, input rdata);
	modport engine (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface // pin_cycle_if

// *** logic/pin_cycle.sv ***
`timescale 1ns/10ps
// Runs one write or read cycle on the flash pins
module pin_cycle import flash_host_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	pin_cycle_if.engine cyc,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [FLASH_AW-1:0] fa,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic [7:0] dq_in
);
	typedef enum logic [2:0] {
		C_IDLE = 3'b000,
		C_SETUP = 3'b001,
		C_STROBE = 3'b010,
		C_RECOVER = 3'b011,
		C_DONE = 3'b100
	} cyc_e;

	cyc_e state; // Cycle phase
	logic [7:0] cnt; // Cycles spent in phase
	logic [7:0] dq_meta; // First sync stage
	logic [7:0] dq_sync; // Second sync stage
	logic [7:0] limit; // Last count of the current phase

	// Reads wait two extra cycles to cover the synchroniser
	assign limit = (state == C_SETUP) ? 8'(SETUP_CYC - 1) :
		(state == C_RECOVER) ? 8'(RECOVER_CYC - 1) :
		cyc.wr ? 8'(STROBE_CYC - 1) : 8'(ACCESS_CYC + 1);
	wire phase_end = (cnt == limit);

	// Data pins come from another domain
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dq_meta <= 8'h00;
			dq_sync <= 8'h00;
		end else begin
			dq_meta <= dq_in;
			dq_sync <= dq_meta;
		end
	end

	// Phase sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= C_IDLE;
			cnt <= 8'h00;
			ce_n <= 1'b1;
			oe_n <= 1'b1;
			we_n <= 1'b1;
			fa <= '0;
			dq_out <= 8'h00;
			dq_oe <= 1'b0;
			cyc.done <= 1'b0;
			cyc.rdata <= 8'h00;
		end else begin
			cnt <= phase_end ? 8'h00 : cnt + 8'h01;
			case (state)
				// Address and data settle with chip enable
				C_IDLE: begin
					cnt <= 8'h00;
					if (cyc.req) begin
						fa <= cyc.addr;
						dq_out <= cyc.wdata;
						dq_oe <= cyc.wr;
						ce_n <= 1'b0;
						state <= C_SETUP;
					end
				end
				// Write strobe, or output enable for a read
				C_SETUP: if (phase_end) begin
					we_n <= ~cyc.wr;
					oe_n <= cyc.wr;
					state <= C_STROBE;
				end
				// latch edge, the active strobe and chip enable rise together
				C_STROBE: if (phase_end) begin
					we_n <= 1'b1;
					oe_n <= 1'b1;
					ce_n <= 1'b1;
					if (!cyc.wr) begin
						cyc.rdata <= dq_sync;
					end
					state <= C_RECOVER;
				end
				// Data held past the latch edge
				C_RECOVER: if (phase_end) begin
					dq_oe <= 1'b0;
					cyc.done <= 1'b1;
					state <= C_DONE;
				end
				C_DONE: begin
					cyc.done <= 1'b0;
					state <= C_IDLE;
				end
				default: state <= C_IDLE;
			endcase
		end
	end

	// Output enable only with write enable high and chip selected
	read_strobe_a: assert property (@(posedge pclk) disable iff (!presetn)
		!oe_n |-> (we_n && !ce_n && !dq_oe)) else $error("read strobe overlaps write");

	// Write latch edge sees the data still driven
	write_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(we_n) |-> dq_oe && $past(!ce_n)) else $error("write latched without data");

endmodule // pin_cycle

// *** logic/flash_host.sv ***
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
module flash_host import flash_host_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic ce_n,
	output logic oe_n,
	output logic we_n,
	output logic [FLASH_AW-1:0] fa,
	output logic [7:0] dq_out,
	output logic dq_oe,
	input wire logic [7:0] dq_in,
	output logic wp_high,
	output logic boot_unlock_voltage,
	output logic reset_powerdown_n,
	output logic program_supply_high,
	output logic identify_select_addr
);
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_SETUP = 3'b001,
		M_COMMIT = 3'b010,
		M_POLL = 3'b011,
		M_RESTORE = 3'b100,
		M_READ = 3'b101,
		M_RESET = 3'b110
	} main_e;

	pin_cycle_if cyc ();

	main_e state; // Sequencer state
	main_e next_state; // Its next value
	op_e op; // Operation in progress
	logic use_wp; // Unlock the boot block by write protect high
	logic use_hv; // Unlock the boot block by elevated reset voltage
	logic [FLASH_AW-1:0] addr; // Target address
	logic [7:0] wdata; // Byte to program
	logic [7:0] flash_stat; // Last status byte once ready
	logic [7:0] rd_data; // Last array or identity byte
	logic [7:0] rcnt; // Reset pulse length
	logic [7:0] last_cmd; // Last byte written to the pins
	logic array_mode; // Device known to be in array read

	// Bus decode
	wire setup_ph = psel & ~penable;
	wire access = psel & penable & pready;
	wire hit_ctrl = (paddr == REG_CTRL);
	wire hit_addr = (paddr == REG_ADDR);
	wire hit_wdata = (paddr == REG_WDATA);
	wire hit_stat = (paddr == REG_STATUS);
	wire mapped = hit_ctrl | hit_addr | hit_wdata | hit_stat;
	wire wr_ok = access & pwrite & mapped;
	wire busy = (state != M_IDLE);
	wire err = |(flash_stat & ERR_MASK);
	wire [2:0] req_op = pwdata[2:0];
	wire op_legal = (req_op != OP_NONE) && (req_op <= OP_RESET);
	// New operations only while idle, so pins and unlocks stay fixed
	wire start = wr_ok & hit_ctrl & ~busy & op_legal;
	wire [31:0] stat_word = {8'h00, rd_data, flash_stat, 6'h00, err, busy};
	wire [31:0] ctrl_word = {27'h0, use_hv, use_wp, op};
	wire [31:0] rd_mux = hit_ctrl ? ctrl_word :
		hit_addr ? {13'h0, addr} :
		hit_wdata ? {24'h0, wdata} :
		hit_stat ? stat_word : 32'h0;
	wire ready_seen = cyc.rdata[READY_BIT];
	wire is_erase = (op == OP_ERASE);
	wire rst_end = (rcnt == 8'(RESET_CYC - 1));

	// Pin cycle requests, held until done
	assign cyc.req = (state == M_SETUP) | (state == M_COMMIT) | (state == M_POLL) |
		(state == M_RESTORE) | (state == M_READ);
	assign cyc.wr = (state == M_SETUP) | (state == M_COMMIT) | (state == M_RESTORE);
	assign cyc.addr = addr;
	wire [7:0] setup_code = is_erase ? CMD_ERASE_SETUP : CMD_WRITE_SETUP;
	wire [7:0] commit_code = is_erase ? CMD_ERASE_COMMIT : wdata;
	assign cyc.wdata = (state == M_SETUP) ? setup_code :
		(state == M_COMMIT) ? commit_code :
		(state == M_RESTORE) ? CMD_READ_ARRAY : 8'h00;

	// Next state
	always_comb begin
		next_state = state;
		case (state)
			M_IDLE: if (start) begin
				if (req_op == OP_RESET) begin
					next_state = M_RESET;
				end else if (req_op == OP_PROG || req_op == OP_ERASE) begin
					next_state = M_SETUP;
				end else begin
					next_state = M_READ;
				end
			end
			M_SETUP: if (cyc.done) begin
				next_state = M_COMMIT;
			end
			M_COMMIT: if (cyc.done) begin
				next_state = M_POLL;
			end
			M_POLL: if (cyc.done && ready_seen) begin
				next_state = M_RESTORE;
			end
			M_RESTORE: if (cyc.done) begin
				next_state = M_IDLE;
			end
			M_READ: if (cyc.done) begin
				next_state = M_IDLE;
			end
			M_RESET: if (rst_end) begin
				next_state = M_IDLE;
			end
			default: next_state = M_IDLE;
		endcase
	end

	// State and captured results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= M_IDLE;
			flash_stat <= 8'h00;
			rd_data <= 8'h00;
			rcnt <= 8'h00;
		end else begin
			state <= next_state;
			rcnt <= (state == M_RESET) ? rcnt + 8'h01 : 8'h00;
			if (state == M_POLL && cyc.done && ready_seen) begin
				flash_stat <= cyc.rdata;
			end
			if (state == M_READ && cyc.done) begin
				rd_data <= cyc.rdata;
			end
		end
	end

	// Software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op <= OP_NONE;
			use_wp <= 1'b0;
			use_hv <= 1'b0;
			addr <= '0;
			wdata <= 8'h00;
		end else begin
			if (start) begin
				op <= op_e'(req_op);
				use_wp <= pwdata[CTRL_WP_BIT];
				use_hv <= pwdata[CTRL_HV_BIT];
			end
			// Target changes ignored mid-operation
			if (wr_ok & hit_addr & ~busy) begin
				addr <= pwdata[FLASH_AW-1:0];
			end
			if (wr_ok & hit_wdata & ~busy) begin
				wdata <= pwdata[7:0];
			end
		end
	end

	// Bus answer: no wait states, error on unmapped offsets
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
		end else begin
			pready <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			if (setup_ph) begin
				prdata <= pwrite ? 32'h0 : rd_mux;
			end
		end
	end

	// Supply, unlock and identify levels held for the whole operation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_supply_high <= 1'b0;
			wp_high <= 1'b0;
			boot_unlock_voltage <= 1'b0;
			identify_select_addr <= 1'b0;
			reset_powerdown_n <= 1'b1;
		end else if (start) begin
			program_supply_high <= (req_op == OP_PROG) || (req_op == OP_ERASE);
			wp_high <= pwdata[CTRL_WP_BIT];
			boot_unlock_voltage <= pwdata[CTRL_HV_BIT];
			identify_select_addr <= (req_op == OP_IDENT);
			reset_powerdown_n <= (req_op != OP_RESET);
		end else if (next_state == M_IDLE) begin
			program_supply_high <= 1'b0;
			wp_high <= 1'b0;
			boot_unlock_voltage <= 1'b0;
			identify_select_addr <= 1'b0;
			reset_powerdown_n <= 1'b1;
		end
	end

	// Tracks device mode, read only by checks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_cmd <= 8'h00;
			array_mode <= 1'b1;
		end else if (state == M_RESET) begin
			array_mode <= 1'b1;
		end else if (cyc.done && cyc.wr) begin
			last_cmd <= cyc.wdata;
			array_mode <= (cyc.wdata == CMD_READ_ARRAY);
		end
	end

	pin_cycle u_pin_cycle (
		.pclk(pclk),
		.presetn(presetn),
		.cyc(cyc),
		.ce_n(ce_n),
		.oe_n(oe_n),
		.we_n(we_n),
		.fa(fa),
		.dq_out(dq_out),
		.dq_oe(dq_oe),
		.dq_in(dq_in)
	);

	erase_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == M_COMMIT && is_erase) |-> (last_cmd == CMD_ERASE_SETUP) && program_supply_high)
		else $error("erase commit without setup or supply");

	prog_pair_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == M_COMMIT && op == OP_PROG) |-> (last_cmd == CMD_WRITE_SETUP) && program_supply_high)
		else $error("program data without setup or supply");

	array_back_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == M_READ && op == OP_READ) |-> array_mode)
		else $error("array read before read-array command");

	unlock_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		($fell(wp_high) || $fell(boot_unlock_voltage)) |-> (state == M_IDLE) && $past(cyc.done))
		else $error("unlock dropped during operation");

	poll_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == M_POLL && cyc.done && !ready_seen) |=> (state == M_POLL) && cyc.req)
		else $error("poll left while device busy");

	stat_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state == M_POLL && cyc.done && ready_seen) |=>
			(flash_stat == $past(cyc.rdata)) && (state == M_RESTORE))
		else $error("ready status not captured");

endmodule // flash_host

// *** tb/flash_model.sv ***
`timescale 1ns/10ps
// Byte-wide boot-block flash, boot block at the bottom of the map
module flash_model #(
	parameter int BUSY_NS = 400, // Engine time, kept short for simulation
	parameter logic [7:0] MAKER_ID = 8'h5a, // Arbitrary value
	parameter logic [7:0] PART_ID = 8'ha6 // Arbitrary value
) (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [18:0] fa,
	input wire logic [7:0] dq_out,
	input wire logic dq_oe,
	output logic [7:0] dq_in,
	input wire logic wp_high,
	input wire logic boot_unlock_voltage,
	input wire logic reset_powerdown_n,
	input wire logic program_supply_high,
	input wire logic identify_select_addr
);
	logic [7:0] mem [0:524287]; // Whole array
	logic [7:0] sr = 8'h80; // Status byte, bit 7 ready
	logic mode = 1'b0; // High while reads return status
	logic [7:0] pend = 8'h00; // Setup code waiting for its second write
	logic boot_op = 1'b0; // Boot block operation in flight
	logic [7:0] held = 8'h00; // Last byte driven
	logic armed = 1'b0; // A real write strobe was seen
	logic ok; // Operation allowed
	wire wr_strobe = !ce_n && !we_n && oe_n && reset_powerdown_n;
	wire rd_en = !ce_n && !oe_n && we_n && reset_powerdown_n;
	wire unlock = wp_high || boot_unlock_voltage;
	wire [7:0] rd_val = identify_select_addr ? (fa[0] ? PART_ID : MAKER_ID) : mode ? sr : mem[fa];
	function automatic int blk(input int a);
		return (a < 32'h4000) ? 0 : (a < 32'h6000) ? 1 : (a < 32'h8000) ? 2 : 3 + (a >> 17);
	endfunction
	initial for (int k = 0; k < 524288; k++) mem[k] = 8'hff;
	// Released bus shows the inverse, so stale data never passes
	always @(negedge rd_en) held = rd_val;
	assign dq_in = dq_oe ? dq_out : rd_en ? rd_val : ~held;
	task automatic begin_op(input int flag);
		boot_op = (blk(fa) == 0);
		ok = program_supply_high && (!boot_op || unlock);
		sr[3] = sr[3] | !program_supply_high;
		sr[flag] = sr[flag] | !ok;
		mode = 1'b1;
		pend = 8'h00;
		sr[7] = 1'b0;
		sr[7] <= #(BUSY_NS) 1'b1;
	endtask
	always @(posedge wr_strobe) armed = 1'b1;
	// First rising enable latches; busy ignores
	always @(negedge wr_strobe) begin
		if (!armed) begin
			pend = 8'h00;
		end else if (!sr[7]) begin
			pend = 8'h00;
		end else if (pend == 8'h40 || pend == 8'h10) begin
			begin_op(4);
			if (ok) mem[fa] = mem[fa] & dq_out;
		end else if (pend == 8'h20) begin
			begin_op(5);
			if (dq_out != 8'hd0) sr[5:4] = 2'b11;
			if (ok && dq_out == 8'hd0) for (int k = 0; k < 524288; k++) if (blk(k) == blk(fa)) mem[k] = 8'hff;
		end else begin
			pend = dq_out;
			mode = (dq_out != 8'hff);
		end
		armed = 1'b0;
	end
	always @(unlock) if (!sr[7] && boot_op && !unlock) sr[4] = 1'b1;
	always @(negedge reset_powerdown_n) begin
		sr = 8'h80;
		mode = 1'b0;
		pend = 8'h00;
	end
endmodule // flash_model

// *** tb/tb_top.sv ***
`timescale 1ns/10ps
module tb_top import flash_host_pkg::*;;
	localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
	localparam logic [7:0] PART = 8'ha6; // Arbitrary value
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, ce_n, oe_n, we_n, dq_oe, wp_high, boot_unlock_voltage;
	wire reset_powerdown_n, program_supply_high, identify_select_addr;
	wire [FLASH_AW-1:0] fa;
	wire [7:0] dq_out, dq_in;
	int num_errors = 0;
	int total_checks = 0;
	logic [31:0] r; // Last read data
	logic [31:0] st; // Last idle status
	logic err; // Last slave error
	flash_host flash_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ce_n, .oe_n, .we_n, .fa, .dq_out, .dq_oe, .dq_in,
		.wp_high, .boot_unlock_voltage, .reset_powerdown_n, .program_supply_high,
		.identify_select_addr);
	flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash_model_i (.ce_n, .oe_n, .we_n, .fa,
		.dq_out, .dq_oe, .dq_in, .wp_high, .boot_unlock_voltage, .reset_powerdown_n,
		.program_supply_high, .identify_select_addr);
	initial forever #2.5 pclk = ~pclk;
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			stop_test();
		end
	endtask
	// Poll status until the operation ends
	task automatic wait_idle();
		int n;
		n = 0;
		do begin
			apb(1'b0, REG_STATUS, 32'h0);
			n++;
		end while (r[STAT_BUSY_BIT] !== 1'b0 && n < 1000);
		st = r;
		// A hang ends the run here, nothing may follow the verdict
		if (r[STAT_BUSY_BIT] !== 1'b0) begin
			num_errors++;
			stop_test();
		end
	endtask
	task automatic run_op(input op_e op, input logic [18:0] a, input logic [7:0] d,
		input logic [1:0] unl);
		apb(1'b1, REG_ADDR, 32'(a));
		apb(1'b1, REG_WDATA, 32'(d));
		apb(1'b1, REG_CTRL, {27'h0, unl, op});
		wait_idle();
	endtask
	task automatic rd(input logic [18:0] a);
		run_op(OP_READ, a, 8'h00, 2'b00);
	endtask
	task automatic t_reset();
		check(32'({ce_n, oe_n, we_n, dq_oe, reset_powerdown_n}), 32'h1d);
		wait_idle();
		check(st, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check(32'(err), 32'h1);
	endtask
	task automatic t_program();
		rd(19'h30000);
		check(32'(st[23:16]), 32'hff);
		run_op(OP_PROG, 19'h30000, 8'h5a, 2'b00);
		check(32'(st[15:0]), 32'h8000);
		run_op(OP_PROG, 19'h30000, 8'hf0, 2'b00);
		rd(19'h30000);
		check(32'(st[23:16]), 32'h50);
	endtask
	task automatic t_boot();
		run_op(OP_PROG, 19'h00100, 8'h00, 2'b00);
		check(32'(st[15:0]), 32'h9002);
		rd(19'h00100);
		check(32'(st[23:16]), 32'hff);
		run_op(OP_RESET, 19'h0, 8'h00, 2'b00);
		run_op(OP_PROG, 19'h00100, 8'h3c, 2'b01);
		check(32'(st[15:0]), 32'h8000);
		apb(1'b1, REG_ADDR, 32'h101);
		apb(1'b1, REG_WDATA, 32'h0f);
		apb(1'b1, REG_CTRL, {27'h0, 2'b10, OP_PROG});
		repeat (2) @(posedge pclk);
		check(32'(boot_unlock_voltage), 32'h1);
		wait_idle();
		check(32'(st[15:0]), 32'h8000);
		rd(19'h00101);
		check(32'(st[23:16]), 32'h0f);
	endtask
	task automatic t_erase();
		run_op(OP_PROG, 19'h04000, 8'h11, 2'b00);
		run_op(OP_PROG, 19'h06000, 8'h22, 2'b00);
		run_op(OP_ERASE, 19'h04abc, 8'h00, 2'b00);
		check(32'(st[15:0]), 32'h8000);
		rd(19'h04000);
		check(32'(st[23:16]), 32'hff);
		rd(19'h06000);
		check(32'(st[23:16]), 32'h22);
		rd(19'h30000);
		check(32'(st[23:16]), 32'h50);
		run_op(OP_ERASE, 19'h00000, 8'h00, 2'b00);
		check(32'(st[15:0]), 32'ha002);
		rd(19'h00100);
		check(32'(st[23:16]), 32'h3c);
	endtask
	task automatic t_ident();
		run_op(OP_IDENT, 19'h0, 8'h00, 2'b00);
		check(32'(st[23:16]), 32'(MAKER));
		run_op(OP_IDENT, 19'h1, 8'h00, 2'b00);
		check(32'(st[23:16]), 32'(PART));
	endtask
	// Register readback, then target and control frozen while busy
	task automatic t_regs();
		// Upper address bits beyond the flash are dropped
		apb(1'b1, REG_ADDR, 32'hfff12345);
		apb(1'b0, REG_ADDR, 32'h0);
		check(r, 32'h00012345);
		apb(1'b1, REG_WDATA, 32'h1a5);
		apb(1'b0, REG_WDATA, 32'h0);
		check(r, 32'h000000a5);
		// Start a program in a main block, then try to disturb it
		apb(1'b1, REG_ADDR, 32'h50000);
		apb(1'b1, REG_WDATA, 32'h66);
		apb(1'b1, REG_CTRL, {27'h0, 2'b00, OP_PROG});
		apb(1'b1, REG_ADDR, 32'h50001);
		apb(1'b1, REG_CTRL, {27'h0, 2'b01, OP_ERASE});
		apb(1'b0, REG_CTRL, 32'h0);
		check(r, 32'h00000002);
		check(32'(wp_high), 32'h0);
		wait_idle();
		apb(1'b0, REG_ADDR, 32'h0);
		check(r, 32'h00050000);
		rd(19'h50000);
		check(32'(st[23:16]), 32'h66);
	endtask
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_program();
		t_boot();
		t_erase();
		t_ident();
		t_regs();
		stop_test();
	end
endmodule // tb_top
